// ==== core/sfs_can_mon.sv ====
// per-interface can status registers and warning threshold
`timescale 1ns/1ps
module sfs_can_mon import sfs_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic bus_off_i,
  input wire logic [7:0] rx_cnt_i,
  input wire logic [7:0] tx_cnt_i,
  input wire logic [7:0] lec_i,
  output logic [31:0] word_o
);
  logic warn;
  always_comb begin
    warn = (rx_cnt_i >= SFS_CAN_WARN_LIMIT) ||
           (tx_cnt_i >= SFS_CAN_WARN_LIMIT); // RULE15
  end
  // word layout from the top: warn, bus off, lec, tx count, rx count
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      word_o <= 32'h0000_0000;
    end else begin
      word_o <= {6'h00, warn, bus_off_i, lec_i, tx_cnt_i,
                 rx_cnt_i}; // RULE14 RULE16
    end
  end
  property p_warn;
    @(posedge clk_i) disable iff (reset_i)
    ((rx_cnt_i >= SFS_CAN_WARN_LIMIT) || (tx_cnt_i >= SFS_CAN_WARN_LIMIT))
      |=> word_o[25];
  endproperty
  a_warn: assert property (p_warn) // RULE15
    else $error("warning missing at threshold");
  property p_warnoff;
    @(posedge clk_i) disable iff (reset_i)
    ((rx_cnt_i < SFS_CAN_WARN_LIMIT) && (tx_cnt_i < SFS_CAN_WARN_LIMIT))
      |=> !word_o[25];
  endproperty
  a_warnoff: assert property (p_warnoff) // RULE15
    else $error("warning below threshold");
  property p_lec;
    @(posedge clk_i) disable iff (reset_i)
    (lec_i == SFS_LEC_NONE) |=> (word_o[23:16] == SFS_LEC_NONE);
  endproperty
  a_lec: assert property (p_lec) // RULE16
    else $error("error code not zero after clean transfer");
endmodule : sfs_can_mon

// ==== core/sfs_pkg.sv ====
// package with register map, field layout and constants of the fault supervisor
package sfs_pkg;
  localparam int SFS_GROUPS = 2;
  localparam int SFS_CANS = 2;
  localparam logic [7:0] SFS_CAN_WARN_LIMIT = 8'h60;
  localparam logic [7:0] SFS_LEC_NONE = 8'h00;
  localparam int SFS_TEMP_LIMIT_C = 85;
  localparam logic [11:0] SFS_A_CTRL = 12'h000;
  localparam logic [11:0] SFS_A_STAT = 12'h004;
  localparam logic [11:0] SFS_A_FATAL = 12'h008;
  localparam logic [11:0] SFS_A_BREAK = 12'h00c;
  localparam logic [11:0] SFS_A_PERIPH = 12'h010;
  localparam logic [11:0] SFS_A_SHORT = 12'h014;
  localparam logic [11:0] SFS_A_SAFECFG = 12'h018;
  localparam logic [11:0] SFS_A_CAN0 = 12'h020;
  localparam logic [11:0] SFS_A_CAN1 = 12'h024;
  // ctrl bits
  localparam int SFS_C_MASTER = 0;
  localparam int SFS_C_CANSAFE_EN = 1;
  // status bits
  localparam int SFS_S_MASTER = 0;
  localparam int SFS_S_TEMP = 1;
  localparam int SFS_S_IO = 2;
  localparam int SFS_S_CROSS = 3;
  localparam int SFS_S_CANSAFE = 4;
  localparam int SFS_S_ANALOG = 5;
  localparam int SFS_S_POWER = 6;
  localparam int SFS_S_VOUT = 7;
  localparam int SFS_S_VREL = 8;
  localparam int SFS_S_BITS = 9;
  localparam int SFS_FATAL_BITS = 8;

  typedef struct packed {
    logic [SFS_S_BITS-1:0] stat;
    logic [SFS_FATAL_BITS-1:0] fatal;
    logic [SFS_GROUPS-1:0][7:0] brk;
    logic [SFS_GROUPS-1:0][7:0] per;
    logic [SFS_GROUPS-1:0][7:0] sht;
    logic [SFS_GROUPS-1:0][7:0] safecfg_in;
    logic [SFS_GROUPS-1:0][7:0] safecfg_out;
    logic cansafe_en;
    logic [31:0] prdata;
  } sfs_state_t;

  typedef struct packed {
    logic relay_on;
    logic led_red;
    logic outputs_off;
    logic error_n;
    logic cpu_halt;
    logic comm_off;
    logic diag_hold;
  } sfs_act_t;
endpackage : sfs_pkg

// ==== core/sfs_sticky.sv ====
// sticky flag vector: set wins over software clear
`timescale 1ns/1ps
module sfs_sticky import sfs_pkg::*; #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] next_q;
  always_comb begin
    next_q = (q_o & ~clr_i) | set_i; // RULE1 RULE21
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q_o <= '0;
    end else begin
      q_o <= next_q;
    end
  end
  property p_hold;
    @(posedge clk_i) disable iff (reset_i)
    ((($past(q_o) & ~$past(clr_i)) & ~q_o) == '0);
  endproperty
  a_hold: assert property (p_hold) // RULE1
    else $error("flag dropped without clear");
  property p_setwins;
    @(posedge clk_i) disable iff (reset_i)
    (|set_i) |=> ((q_o & $past(set_i)) == $past(set_i));
  endproperty
  a_setwins: assert property (p_setwins) // RULE21
    else $error("set lost against clear");
endmodule : sfs_sticky

// ==== core/sfs_top.sv ====
// safety fault supervisor: fault classes, shutdown actions, apb registers
// Contract
// RULE1: flags stay set until software clears
// RULE2: software may set master error flag
// RULE3: slight faults only flag, no shutdown
// RULE4: byte flags per group, three fault types
// RULE5: safety-configured group faults become serious
// RULE6: master flag: led red, relay off
// RULE7: relay shutdown keeps output state registers
// RULE8: error pin low while master flag set
// RULE9: over-temperature flag above eighty five degrees
// RULE10: combined io flag plus cross flag
// RULE11: serious fault keeps cpu and comms running
// RULE12: serious fault suspends wire diagnosis
// RULE13: safe can fault: flag, outputs off, red
// RULE14: per can: bus-off, rx, tx counters
// RULE15: can warning at ninety six or more
// RULE16: last error code zero means none
// RULE17: eight fatal fault flags
// RULE18: fatal fault halts cpu and comms
// RULE19: test input turns fatal into serious
// RULE20: cleared master flag re-energises relay
// RULE21: detection beats same-cycle clear
`timescale 1ns/1ps
module sfs_top import sfs_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SFS_GROUPS-1:0][7:0] output_wire_break_group_i,
  input wire logic [SFS_GROUPS-1:0][7:0] input_peripheral_fault_group_i,
  input wire logic [SFS_GROUPS-1:0][7:0] output_short_group_i,
  input wire logic over_temp_i,
  input wire logic cross_fault_i,
  input wire logic safety_output_cross_fault_i,
  input wire logic analog_fault_i,
  input wire logic power_fault_i,
  input wire logic output_supply_missing_i,
  input wire logic relay_supply_missing_i,
  input wire logic can_safe_fault_i,
  input wire logic [SFS_FATAL_BITS-1:0] fatal_fault_i,
  input wire logic test_mode_i,
  input wire logic [SFS_CANS-1:0] bus_off_flag_i,
  input wire logic [SFS_CANS-1:0][7:0] rx_fault_counter_i,
  input wire logic [SFS_CANS-1:0][7:0] tx_fault_counter_i,
  input wire logic [SFS_CANS-1:0][7:0] last_transfer_fault_code_i,
  output sfs_act_t act_o
);
  sfs_state_t r;
  sfs_state_t next_r;
  logic wr;
  logic rd;
  logic [SFS_S_BITS-1:0] stat_set;
  logic [SFS_S_BITS-1:0] stat_clr;
  logic [SFS_S_BITS-1:0] stat_q;
  logic [SFS_FATAL_BITS-1:0] fatal_clr;
  logic [SFS_FATAL_BITS-1:0] fatal_q;
  logic [3*SFS_GROUPS*8-1:0] grp_set;
  logic [3*SFS_GROUPS*8-1:0] grp_clr;
  logic [3*SFS_GROUPS*8-1:0] grp_q;
  logic [SFS_CANS-1:0][31:0] can_word;
  logic diag_hold;
  logic safe_grp;
  logic any_fatal;
  logic serious;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction : hit

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = r.prdata;

  genvar gc;
  generate
    for (gc = 0; gc < SFS_CANS; gc++) begin : g_can
      sfs_can_mon u_can (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .bus_off_i(bus_off_flag_i[gc]),
        .rx_cnt_i(rx_fault_counter_i[gc]),
        .tx_cnt_i(tx_fault_counter_i[gc]),
        .lec_i(last_transfer_fault_code_i[gc]),
        .word_o(can_word[gc])
      );
    end
  endgenerate

  // diagnosis suspended while master flag or a fatal flag stands
  assign diag_hold = stat_q[SFS_S_MASTER] | any_fatal; // RULE12
  assign any_fatal = |fatal_q;

  always_comb begin
    safe_grp = 1'b0;
    for (int g = 0; g < SFS_GROUPS; g++) begin
      safe_grp = safe_grp |
        |(output_wire_break_group_i[g] & r.safecfg_out[g]) |
        |(output_short_group_i[g] & r.safecfg_out[g]) |
        |(input_peripheral_fault_group_i[g] & r.safecfg_in[g]); // RULE5
    end
    if (diag_hold) begin
      safe_grp = 1'b0; // RULE12
    end
  end

  always_comb begin
    grp_set = diag_hold ? '0 :
      {output_short_group_i, input_peripheral_fault_group_i,
       output_wire_break_group_i}; // RULE4 RULE12
    grp_clr = '0;
    if (wr && hit(paddr, SFS_A_BREAK)) begin
      grp_clr[SFS_GROUPS*8-1:0] = pwdata[SFS_GROUPS*8-1:0];
    end
    if (wr && hit(paddr, SFS_A_PERIPH)) begin
      grp_clr[2*SFS_GROUPS*8-1:SFS_GROUPS*8] = pwdata[SFS_GROUPS*8-1:0];
    end
    if (wr && hit(paddr, SFS_A_SHORT)) begin
      grp_clr[3*SFS_GROUPS*8-1:2*SFS_GROUPS*8] = pwdata[SFS_GROUPS*8-1:0];
    end
  end

  // slight faults never reach the master flag unless safety-configured
  always_comb begin
    stat_set = '0;
    stat_set[SFS_S_TEMP] = over_temp_i; // RULE9
    stat_set[SFS_S_IO] = !diag_hold && (cross_fault_i ||
      |output_wire_break_group_i || |output_short_group_i); // RULE10
    stat_set[SFS_S_CROSS] = safety_output_cross_fault_i; // RULE10
    stat_set[SFS_S_CANSAFE] = r.cansafe_en && can_safe_fault_i; // RULE13
    stat_set[SFS_S_ANALOG] = analog_fault_i;
    stat_set[SFS_S_POWER] = power_fault_i;
    stat_set[SFS_S_VOUT] = output_supply_missing_i;
    stat_set[SFS_S_VREL] = relay_supply_missing_i;
    stat_set[SFS_S_MASTER] = safe_grp || stat_set[SFS_S_CANSAFE] ||
      (wr && hit(paddr, SFS_A_CTRL) && pwdata[SFS_C_MASTER]); // RULE2 RULE5 RULE3
    stat_clr = '0;
    if (wr && hit(paddr, SFS_A_STAT)) begin
      stat_clr = pwdata[SFS_S_BITS-1:0]; // RULE1
    end
    fatal_clr = '0;
    if (wr && hit(paddr, SFS_A_FATAL)) begin
      fatal_clr = pwdata[SFS_FATAL_BITS-1:0];
    end
  end

  sfs_sticky #(.W(SFS_S_BITS)) u_stat (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .set_i(stat_set),
    .clr_i(stat_clr),
    .q_o(stat_q)
  );
  sfs_sticky #(.W(SFS_FATAL_BITS)) u_fatal (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .set_i(fatal_fault_i), // RULE17
    .clr_i(fatal_clr),
    .q_o(fatal_q)
  );
  sfs_sticky #(.W(3*SFS_GROUPS*8)) u_grp (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .set_i(grp_set),
    .clr_i(grp_clr),
    .q_o(grp_q)
  );

  always_comb begin
    next_r = r;
    next_r.stat = stat_q;
    next_r.fatal = fatal_q;
    next_r.brk = grp_q[SFS_GROUPS*8-1:0];
    next_r.per = grp_q[2*SFS_GROUPS*8-1:SFS_GROUPS*8];
    next_r.sht = grp_q[3*SFS_GROUPS*8-1:2*SFS_GROUPS*8];
    if (wr && hit(paddr, SFS_A_CTRL)) begin
      next_r.cansafe_en = pwdata[SFS_C_CANSAFE_EN];
    end
    if (wr && hit(paddr, SFS_A_SAFECFG)) begin
      next_r.safecfg_in = pwdata[SFS_GROUPS*8-1:0];
      next_r.safecfg_out = pwdata[2*SFS_GROUPS*8-1:SFS_GROUPS*8];
    end
    if (rd) begin
      case (paddr)
        SFS_A_CTRL: next_r.prdata = {30'h0, r.cansafe_en,
                                     stat_q[SFS_S_MASTER]};
        SFS_A_STAT: next_r.prdata = 32'(stat_q);
        SFS_A_FATAL: next_r.prdata = 32'(fatal_q);
        SFS_A_BREAK: next_r.prdata = 32'(r.brk);
        SFS_A_PERIPH: next_r.prdata = 32'(r.per);
        SFS_A_SHORT: next_r.prdata = 32'(r.sht);
        SFS_A_SAFECFG: next_r.prdata = {r.safecfg_out, r.safecfg_in};
        SFS_A_CAN0: next_r.prdata = can_word[0];
        SFS_A_CAN1: next_r.prdata = can_word[1];
        default: next_r.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        SFS_A_CTRL, SFS_A_STAT, SFS_A_FATAL, SFS_A_BREAK, SFS_A_PERIPH,
        SFS_A_SHORT, SFS_A_SAFECFG, SFS_A_CAN0, SFS_A_CAN1: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  // actions: only master, fatal or can-safety flags act, slight ones never
  assign serious = stat_q[SFS_S_MASTER] | stat_q[SFS_S_CANSAFE] | any_fatal;
  always_comb begin
    act_o.relay_on = !serious; // RULE6 RULE13 RULE20 RULE3
    act_o.led_red = serious; // RULE6 RULE13 RULE18 RULE20
    // relay cuts power only; output state registers live elsewhere untouched
    act_o.outputs_off = serious; // RULE7 RULE13 RULE18 RULE19
    act_o.error_n = !stat_q[SFS_S_MASTER]; // RULE8
    act_o.cpu_halt = any_fatal && !test_mode_i; // RULE11 RULE18 RULE19
    act_o.comm_off = any_fatal && !test_mode_i; // RULE11 RULE18 RULE19
    act_o.diag_hold = diag_hold; // RULE12
  end

  property p_errpin;
    @(posedge clk_i) disable iff (reset_i)
    act_o.error_n == !stat_q[SFS_S_MASTER];
  endproperty
  a_errpin: assert property (p_errpin) // RULE8
    else $error("error pin wrong");
  property p_relay;
    @(posedge clk_i) disable iff (reset_i)
    stat_q[SFS_S_MASTER] |-> !act_o.relay_on && act_o.led_red;
  endproperty
  a_relay: assert property (p_relay) // RULE6
    else $error("relay on under master flag");
  property p_swset;
    @(posedge clk_i) disable iff (reset_i)
    (wr && paddr == SFS_A_CTRL && pwdata[SFS_C_MASTER])
      |=> !act_o.relay_on;
  endproperty
  a_swset: assert property (p_swset) // RULE2
    else $error("software master set ignored");
  property p_slight;
    @(posedge clk_i) disable iff (reset_i)
    !serious |-> act_o.relay_on && !act_o.outputs_off;
  endproperty
  a_slight: assert property (p_slight) // RULE3
    else $error("shutdown without serious fault");
  property p_fatal;
    @(posedge clk_i) disable iff (reset_i)
    (any_fatal && !test_mode_i) |-> act_o.cpu_halt && act_o.comm_off;
  endproperty
  a_fatal: assert property (p_fatal) // RULE18
    else $error("fatal did not halt");
  property p_test;
    @(posedge clk_i) disable iff (reset_i)
    (any_fatal && test_mode_i) |-> !act_o.cpu_halt && act_o.outputs_off;
  endproperty
  a_test: assert property (p_test) // RULE19
    else $error("test mode fatal handling wrong");
  property p_cansafe;
    @(posedge clk_i) disable iff (reset_i)
    (r.cansafe_en && can_safe_fault_i)
      |=> stat_q[SFS_S_CANSAFE] && act_o.outputs_off;
  endproperty
  a_cansafe: assert property (p_cansafe) // RULE13
    else $error("can safety fault not acted on");
  property p_temp;
    @(posedge clk_i) disable iff (reset_i)
    over_temp_i |=> stat_q[SFS_S_TEMP];
  endproperty
  a_temp: assert property (p_temp) // RULE9
    else $error("temperature flag missing");
  property p_hold;
    @(posedge clk_i) disable iff (reset_i)
    diag_hold |=> ((grp_q & ~$past(grp_q)) == '0);
  endproperty
  a_hold: assert property (p_hold) // RULE12
    else $error("diagnosis not suspended");
  property p_relayback;
    @(posedge clk_i) disable iff (reset_i)
    (!stat_q[SFS_S_MASTER] && !stat_q[SFS_S_CANSAFE] && !any_fatal)
      |-> act_o.relay_on && !act_o.led_red;
  endproperty
  a_relayback: assert property (p_relayback) // RULE20
    else $error("relay not back after clear");
  property p_escal;
    @(posedge clk_i) disable iff (reset_i)
    (!diag_hold && |(output_short_group_i[0] & r.safecfg_out[0]))
      |=> stat_q[SFS_S_MASTER];
  endproperty
  a_escal: assert property (p_escal) // RULE5
    else $error("safety group fault not escalated");
  property p_ioheld;
    @(posedge clk_i) disable iff (reset_i)
    (diag_hold && !stat_q[SFS_S_IO]) |=> !stat_q[SFS_S_IO];
  endproperty
  a_ioheld: assert property (p_ioheld) // RULE12
    else $error("io diagnosis ran while suspended");
  property p_keep;
    @(posedge clk_i) disable iff (reset_i)
    (stat_q[SFS_S_TEMP] && !stat_clr[SFS_S_TEMP]) |=> stat_q[SFS_S_TEMP];
  endproperty
  a_keep: assert property (p_keep) // RULE1
    else $error("status flag cleared by itself");
  property p_wrclr;
    @(posedge clk_i) disable iff (reset_i)
    (wr && paddr == SFS_A_STAT && pwdata[SFS_S_TEMP] && !over_temp_i)
      |=> !stat_q[SFS_S_TEMP];
  endproperty
  a_wrclr: assert property (p_wrclr) // RULE1
    else $error("software clear ignored");
  property p_fatalset;
    @(posedge clk_i) disable iff (reset_i)
    (|fatal_fault_i) |=> any_fatal;
  endproperty
  a_fatalset: assert property (p_fatalset) // RULE17
    else $error("fatal flag missing");
  property p_quiet;
    @(posedge clk_i) disable iff (reset_i)
    (!serious && !wr && !safe_grp && !can_safe_fault_i && !(|fatal_fault_i))
      |=> act_o.relay_on && !act_o.led_red;
  endproperty
  a_quiet: assert property (p_quiet) // RULE3
    else $error("slight fault caused shutdown");
  property p_prhold;
    @(posedge clk_i) disable iff (reset_i)
    !rd |=> $stable(prdata);
  endproperty
  a_prhold: assert property (p_prhold)
    else $error("read data changed without read");
  property p_errfatal;
    @(posedge clk_i) disable iff (reset_i)
    (any_fatal && !stat_q[SFS_S_MASTER]) |-> act_o.error_n;
  endproperty
  a_errfatal: assert property (p_errfatal) // RULE8
    else $error("error pin low without master flag");
  property p_keeprun;
    @(posedge clk_i) disable iff (reset_i)
    (serious && !any_fatal) |-> !act_o.cpu_halt && !act_o.comm_off;
  endproperty
  a_keeprun: assert property (p_keeprun) // RULE11
    else $error("serious fault halted cpu");
endmodule : sfs_top

// ==== dv/sfs_top_test.sv ====
// self-checking bench for the safety fault supervisor
`timescale 1ns/1ps
module sfs_top_test;
  import sfs_pkg::*;
  // act order: relay, red, off, error_n, halt, comm_off, diag_hold
  localparam logic [6:0] IDLE = 7'b1001000;
  localparam logic [6:0] MAST = 7'b0110001;
  // a can safety fault raises the master flag as well
  localparam logic [6:0] CSF = 7'b0110001;
  localparam logic [6:0] FAT = 7'b0111111;
  localparam logic [6:0] FATT = 7'b0111001;
  logic clk_i, reset_i, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, e;
  logic [SFS_GROUPS-1:0][7:0] brk, per, sht;
  logic [5:0] misc;
  logic over_temp, can_safe, test_mode;
  logic [7:0] fatal, v, r, t;
  logic [SFS_CANS-1:0] bo;
  logic [SFS_CANS-1:0][7:0] rx, tx, lec;
  sfs_act_t act_o;
  int fail_count = 0;
  int n_compared = 0;
  int mbit[6] = '{SFS_S_IO, SFS_S_CROSS, SFS_S_ANALOG, SFS_S_POWER,
    SFS_S_VOUT, SFS_S_VREL};

  sfs_top sfs_top_inst (.clk_i(clk_i), .reset_i(reset_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .output_wire_break_group_i(brk), .input_peripheral_fault_group_i(per),
    .output_short_group_i(sht), .over_temp_i(over_temp),
    .cross_fault_i(misc[0]), .safety_output_cross_fault_i(misc[1]),
    .analog_fault_i(misc[2]), .power_fault_i(misc[3]),
    .output_supply_missing_i(misc[4]), .relay_supply_missing_i(misc[5]),
    .can_safe_fault_i(can_safe), .fatal_fault_i(fatal),
    .test_mode_i(test_mode), .bus_off_flag_i(bo), .rx_fault_counter_i(rx),
    .tx_fault_counter_i(tx), .last_transfer_fault_code_i(lec),
    .act_o(act_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, x, g);
    end
  endtask : chk

  // act is combinational from flags, so look at it mid-cycle
  task automatic chka(input logic [6:0] x);
    @(negedge clk_i);
    n_compared++;
    if (act_o !== sfs_act_t'(x)) begin
      fail_count++;
      $display("CHECK FAILED act exp %b got %b", x, act_o);
    end
    @(posedge clk_i);
  endtask : chka

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    // only the watchdog ends a wait for pready
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge keeps a following request off this edge
    @(posedge clk_i);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a,
      input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, x & m, q & m);
  endtask : rdc

  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask : pause

  initial begin
    pause(20000);
    fail_count++;
    close_out();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {brk, per, sht, misc, over_temp, can_safe, test_mode, fatal} = '0;
    {bo, rx, tx, lec} = '0;
    reset_i = 1'b1;
    pause(4);
    reset_i <= 1'b0;
    pause(1);
    chka(IDLE);
    for (int k = 0; k < 3; k++) begin
      v = 8'h81 + 8'(k);
      if (k == 0) brk[1] <= v;
      else if (k == 1) per[1] <= v;
      else sht[1] <= v;
      pause(2);
      {brk, per, sht} <= '0;
      pause(2);
      chka(IDLE);
      rdc("group", SFS_A_BREAK + 12'(4 * k), {16'h0, v, 8'h0}, '1);
      wr(SFS_A_BREAK + 12'(4 * k), {16'h0, v, 8'h0});
      rdc("group_clr", SFS_A_BREAK + 12'(4 * k), 32'h0, '1);
    end
    rdc("io", SFS_A_STAT, 32'h4, 32'h5);
    wr(SFS_A_STAT, 32'h1ff);
    wr(SFS_A_CTRL, 32'h1);
    chka(MAST);
    brk[0] <= 8'h01;
    pause(2);
    brk[0] <= 8'h00;
    rdc("diag_hold", SFS_A_BREAK, 32'h0, '1);
    wr(SFS_A_STAT, 32'h1);
    chka(IDLE);
    wr(SFS_A_SAFECFG, 32'h0001_0000);
    sht[0] <= 8'h01;
    pause(2);
    sht[0] <= 8'h00;
    rdc("escalate", SFS_A_STAT, 32'h1, 32'h1);
    chka(MAST);
    wr(SFS_A_SAFECFG, 32'h0);
    wr(SFS_A_SHORT, 32'hffff);
    wr(SFS_A_STAT, 32'h1ff);
    for (int i = 0; i < 6; i++) begin
      misc <= 6'(1 << i);
      pause(2);
      misc <= '0;
      e = 32'h1 << mbit[i];
      rdc("flag", SFS_A_STAT, e, e);
      wr(SFS_A_STAT, 32'h1ff);
    end
    over_temp <= 1'b1;
    pause(2);
    wr(SFS_A_STAT, 32'h2);
    rdc("temp", SFS_A_STAT, 32'h2, 32'h2);
    over_temp <= 1'b0;
    wr(SFS_A_STAT, 32'h2);
    rdc("temp_clr", SFS_A_STAT, 32'h0, 32'h2);
    wr(SFS_A_CTRL, 32'h2);
    can_safe <= 1'b1;
    pause(1);
    can_safe <= 1'b0;
    pause(2);
    rdc("cansafe", SFS_A_STAT, 32'h11, 32'h11);
    chka(CSF);
    wr(SFS_A_STAT, 32'h11);
    wr(SFS_A_CTRL, 32'h0);
    chka(IDLE);
    // ninth pass repeats a fatal fault with the test input high
    for (int i = 0; i < 9; i++) begin
      test_mode <= (i == 8);
      fatal <= 8'(1 << (i % 8));
      pause(1);
      fatal <= 8'h00;
      pause(2);
      chka(i == 8 ? FATT : FAT);
      rdc("fatal", SFS_A_FATAL, 32'(1 << (i % 8)), '1);
      wr(SFS_A_FATAL, 32'hff);
    end
    test_mode <= 1'b0;
    chka(IDLE);
    for (int k = 0; k < 4; k++) begin
      r = (k < 2) ? 8'h5f : 8'h60;
      t = (k == 0) ? 8'h60 : 8'h21;
      rx <= (k % 2) ? {r, 8'h00} : {8'h00, r};
      tx <= (k % 2) ? {t, 8'h00} : {8'h00, t};
      lec <= (k % 2) ? {8'(k), 8'h00} : {8'h00, 8'(k)};
      bo <= (k % 2) ? {k[1], 1'b0} : {1'b0, k[1]};
      pause(3);
      e = {6'h0, (r >= SFS_CAN_WARN_LIMIT || t >= SFS_CAN_WARN_LIMIT),
        1'(k[1]), 8'(k), t, r};
      rdc("can", (k % 2) ? SFS_A_CAN1 : SFS_A_CAN0, e, '1);
    end
    apb(1'b0, 12'h01c, 32'h0);
    chk("slverr", 32'h1, {31'h0, last_err});
    chk("unmapped", 32'h0, q);
    close_out();
  end
endmodule : sfs_top_test
